// File: ssq_pkg.sv
// Function
// R1 - Exception reads add one wait after row latch
// R2 - Read page end inserts programmed turn-off cycles
// R3 - Bubbles delay loading only, loaded accesses finish
// R4 - One-cycle bubble: idle once, oldest data latched
// R5 - Two-cycle bubble: idle twice, both latched
// R6 - Longer bubble: drain, then sit column idle
// R7 - Later bubble cycles latch nothing
// R8 - Write row: two address, latch, load, waits
// R9 - Exception in decode aborts via return state
// R10 - Exception writes add two waits after load
// R11 - Write columns: one stage, one per cycle
// R12 - Write stage drives address, status, data, strobes
// R13 - Empty pipeline: idle status, strobes inactive
// R14 - Started column accesses never cancelled
// R15 - After last access: new row or idle
// R16 - Peripheral writes add one automatic turn-off
// R17 - Peripheral writes float bus, transceivers off
// R18 - Write bubble delays next load one cycle
// R19 - Write bubble: idle status, no strobes, data
// R20 - Read row: two address, latch, waits
// R21 - Read address in first stage, data two later
// R22 - Exception inputs sampled in decode state
// R23 - Fixed distinct active and idle status codes
package ssq_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 64;
	localparam int LANE_W = 8;
	localparam int TO_W = 2;
	localparam int CNT_W = 3;
	localparam logic [1:0] STAT_IDLE = 2'h0;
	localparam logic [1:0] STAT_ACTIVE = 2'h1;
	localparam logic [1:0] EXC_NONE = 2'h0;
	localparam logic [CNT_W-1:0] RD_EXI_CNT = 3'h1;
	localparam logic [CNT_W-1:0] WR_EXI_CNT = 3'h2;
	localparam logic [CNT_W-1:0] PDPT_AUTO_RTO = 3'h1;
	localparam logic [LANE_W-1:0] STROBE_OFF = 8'hff;

	typedef enum logic [2:0] {
		SQ_AD1, SQ_AD2, SQ_REX, SQ_RL1, SQ_RCL, SQ_EXI, SQ_COL, SQ_RTO
	} ssq_state_e;
endpackage : ssq_pkg

// File: ssq_sequencer.sv
`timescale 1ns/1ps
module ssq_sequencer
	import ssq_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic mem_clk,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic req_pdpt,
	input wire logic req_exc_en,
	input wire logic [TO_W-1:0] req_turnoff,
	input wire logic req_new_page,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	input wire logic [LANE_W-1:0] req_be,
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	output logic memory_clock_output,
	output logic [ADDR_W-1:0] page_address_bus,
	output logic [1:0] mem_status,
	output logic [LANE_W-1:0] mem_strobe_n,
	output logic mem_we_n,
	output logic [DATA_W-1:0] mem_data_out,
	output logic mem_data_oe,
	input wire logic [DATA_W-1:0] mem_data_in,
	output logic bus_transceiver_enable,
	input wire logic mem_ready,
	input wire logic [1:0] mem_except
);

	////////////////////////////////////////////////////////////////////////////////
	// Request side, system clock

	logic req_t_q;
	logic ak_s1_q, ak_s2_q;
	logic rt_s1_q, rt_s2_q, rt_s3_q;
	logic r_write_q, r_pdpt_q, r_exc_q, r_newpg_q;
	logic [TO_W-1:0] r_to_q;
	logic [ADDR_W-1:0] r_addr_q;
	logic [DATA_W-1:0] r_wdata_q;
	logic [LANE_W-1:0] r_be_q;
	logic ack_t_q;
	logic rd_t_q;
	logic [DATA_W-1:0] m_rd_q;

	// One request in flight; fields stay still until the far side acks
	assign req_ready = (req_t_q == ak_s2_q);

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			req_t_q <= 1'b0;
			r_write_q <= 1'b0;
			r_pdpt_q <= 1'b0;
			r_exc_q <= 1'b0;
			r_newpg_q <= 1'b0;
			r_to_q <= '0;
			r_addr_q <= '0;
			r_wdata_q <= '0;
			r_be_q <= '0;
		end
		else if (req_valid && req_ready)
		begin
			req_t_q <= ~req_t_q;
			r_write_q <= req_write;
			r_pdpt_q <= req_pdpt;
			r_exc_q <= req_exc_en;
			r_newpg_q <= req_new_page;
			r_to_q <= req_turnoff;
			r_addr_q <= req_addr;
			r_wdata_q <= req_wdata;
			r_be_q <= req_be;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ak_s1_q <= 1'b0;
			ak_s2_q <= 1'b0;
			rt_s1_q <= 1'b0;
			rt_s2_q <= 1'b0;
			rt_s3_q <= 1'b0;
		end
		else
		begin
			ak_s1_q <= ack_t_q;
			ak_s2_q <= ak_s1_q;
			rt_s1_q <= rd_t_q;
			rt_s2_q <= rt_s1_q;
			rt_s3_q <= rt_s2_q;
		end
	end

	// Read word is stable long before its toggle is seen here
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			rd_valid <= 1'b0;
			rd_data <= '0;
		end
		else
		begin
			rd_valid <= rt_s2_q ^ rt_s3_q;
			if (rt_s2_q ^ rt_s3_q)
				rd_data <= m_rd_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Memory side, link clock

	logic m_rs1_q, m_rs2_q, mrst_n;
	logic rq_s1_q, rq_s2_q, rq_s3_q;
	logic rdy_s1_q, rdy_s2_q;
	logic [1:0] exc_s1_q, exc_s2_q;
	logic pend_q, p_write_q, p_pdpt_q, p_exc_q, p_newpg_q;
	logic [TO_W-1:0] p_to_q;
	logic [ADDR_W-1:0] p_addr_q;
	logic [DATA_W-1:0] p_wdata_q;
	logic [LANE_W-1:0] p_be_q;
	logic page_open_q, pg_write_q, pg_pdpt_q, pg_exc_q;
	logic [TO_W-1:0] pg_to_q;
	ssq_state_e st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic c1_q, p2_q, p3_q;
	logic need_row, pipe_busy, go, c1_d;
	logic [CNT_W-1:0] rto_cnt;

	assign memory_clock_output = mem_clk;
	assign mrst_n = m_rs2_q;

	always_ff @(posedge mem_clk)
	begin
		m_rs1_q <= rst_n;
		m_rs2_q <= m_rs1_q;
	end

	// Pins and the toggle cross through two flops before use
	always_ff @(posedge mem_clk)
	begin
		if (!mrst_n)
		begin
			rq_s1_q <= 1'b0;
			rq_s2_q <= 1'b0;
			rq_s3_q <= 1'b0;
			rdy_s1_q <= 1'b0;
			rdy_s2_q <= 1'b0;
			exc_s1_q <= EXC_NONE;
			exc_s2_q <= EXC_NONE;
		end
		else
		begin
			rq_s1_q <= req_t_q;
			rq_s2_q <= rq_s1_q;
			rq_s3_q <= rq_s2_q;
			rdy_s1_q <= mem_ready;
			rdy_s2_q <= rdy_s1_q;
			exc_s1_q <= mem_except;
			exc_s2_q <= exc_s1_q;
		end
	end

	always_ff @(posedge mem_clk)
	begin
		if (!mrst_n)
		begin
			pend_q <= 1'b0;
			ack_t_q <= 1'b0;
			p_write_q <= 1'b0;
			p_pdpt_q <= 1'b0;
			p_exc_q <= 1'b0;
			p_newpg_q <= 1'b0;
			p_to_q <= '0;
			p_addr_q <= '0;
			p_wdata_q <= '0;
			p_be_q <= '0;
		end
		else if (rq_s2_q ^ rq_s3_q)
		begin
			pend_q <= 1'b1;
			p_write_q <= r_write_q;
			p_pdpt_q <= r_pdpt_q;
			p_exc_q <= r_exc_q;
			p_newpg_q <= r_newpg_q;
			p_to_q <= r_to_q;
			p_addr_q <= r_addr_q;
			p_wdata_q <= r_wdata_q;
			p_be_q <= r_be_q;
		end
		else
		begin
			if (c1_d)
			begin
				pend_q <= 1'b0;
				ack_t_q <= ~ack_t_q;
			end
			// New-page demand is met once the row opens, else it reopens forever
			if (st_q == SQ_AD1)
				p_newpg_q <= 1'b0;
		end
	end

	// Read/write change or explicit request forces a new page
	assign need_row = pend_q && (!page_open_q || p_newpg_q || (p_write_q != pg_write_q));
	// Read accesses keep the page until their second stage is done
	assign pipe_busy = !pg_write_q && (c1_q || p2_q); // R14
	assign go = pend_q && !need_row; // R3 R18
	assign rto_cnt = CNT_W'(pg_to_q) + ((pg_write_q && pg_pdpt_q) ? PDPT_AUTO_RTO : '0);

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		c1_d = 1'b0;
		unique case (st_q)
			SQ_AD1:
				st_d = SQ_AD2;
			SQ_AD2:
			begin
				if (pg_exc_q && exc_s2_q != EXC_NONE) // R22
					st_d = SQ_REX; // R9
				else if (rdy_s2_q) // R8 R20
					st_d = SQ_RL1;
			end
			SQ_REX:
				st_d = SQ_AD1; // R9
			SQ_RL1:
			begin
				if (pg_write_q)
					st_d = SQ_RCL; // R8
				else if (pg_exc_q)
				begin
					st_d = SQ_EXI; // R1
					cnt_d = RD_EXI_CNT - 3'h1;
				end
				else
				begin
					st_d = SQ_COL;
					c1_d = go;
				end
			end
			SQ_RCL:
			begin
				if (rdy_s2_q && pg_exc_q)
				begin
					st_d = SQ_EXI; // R10
					cnt_d = WR_EXI_CNT - 3'h1;
				end
				else if (rdy_s2_q)
				begin
					st_d = SQ_COL;
					c1_d = go;
				end
			end
			SQ_EXI:
			begin
				if (cnt_q == '0)
				begin
					st_d = SQ_COL;
					c1_d = go;
				end
				else
					cnt_d = cnt_q - 3'h1;
			end
			SQ_COL:
			begin
				c1_d = go; // R11 R6
				if (need_row && !pipe_busy && page_open_q && rto_cnt != '0)
				begin
					st_d = SQ_RTO; // R2 R16 R15
					cnt_d = rto_cnt - 3'h1;
				end
				else if (need_row && !pipe_busy)
					st_d = SQ_AD1; // R15
			end
			SQ_RTO:
			begin
				if (cnt_q == '0)
					st_d = SQ_AD1;
				else
					cnt_d = cnt_q - 3'h1;
			end
		endcase
	end

	always_ff @(posedge mem_clk)
	begin
		if (!mrst_n)
		begin
			st_q <= SQ_COL;
			cnt_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
		end
	end

	// Page mode is frozen at the first address state
	always_ff @(posedge mem_clk)
	begin
		if (!mrst_n)
		begin
			page_open_q <= 1'b0;
			pg_write_q <= 1'b0;
			pg_pdpt_q <= 1'b0;
			pg_exc_q <= 1'b0;
			pg_to_q <= '0;
		end
		else if (st_q == SQ_AD1)
		begin
			page_open_q <= 1'b1;
			pg_write_q <= p_write_q;
			pg_pdpt_q <= p_pdpt_q;
			pg_exc_q <= p_exc_q;
			pg_to_q <= p_to_q;
		end
	end

	// Read pipeline: second and third stages never stall
	always_ff @(posedge mem_clk)
	begin
		if (!mrst_n)
		begin
			c1_q <= 1'b0;
			p2_q <= 1'b0;
			p3_q <= 1'b0;
		end
		else
		begin
			c1_q <= c1_d;
			p2_q <= c1_q && !pg_write_q; // R3 R14
			p3_q <= p2_q;
		end
	end

	always_ff @(posedge mem_clk)
	begin
		if (!mrst_n)
		begin
			rd_t_q <= 1'b0;
			m_rd_q <= '0;
		end
		else if (p3_q)
		begin
			rd_t_q <= ~rd_t_q; // R21 R4 R5 R7
			m_rd_q <= mem_data_in;
		end
	end

	// Pin drivers are flops set for the cycle they describe
	always_ff @(posedge mem_clk)
	begin
		if (!mrst_n)
		begin
			page_address_bus <= '0;
			mem_status <= STAT_IDLE;
			mem_strobe_n <= STROBE_OFF;
			mem_we_n <= 1'b1;
			mem_data_out <= '0;
			mem_data_oe <= 1'b0;
			bus_transceiver_enable <= 1'b1;
		end
		else
		begin
			if (c1_d || st_d == SQ_AD1)
				page_address_bus <= p_addr_q;
			mem_status <= c1_d ? STAT_ACTIVE : STAT_IDLE; // R13 R19 R23
			if (c1_d && p_write_q)
				mem_strobe_n <= ~p_be_q; // R12
			else if (c1_d)
				mem_strobe_n <= '0;
			else
				mem_strobe_n <= STROBE_OFF; // R13 R19
			mem_we_n <= !(c1_d && p_write_q);
			mem_data_out <= (c1_d && p_write_q) ? p_wdata_q : '0;
			mem_data_oe <= c1_d && p_write_q && !p_pdpt_q; // R12 R17
			bus_transceiver_enable <= p_pdpt_q || !(c1_d || page_open_q); // R17
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	a_idle_strobes: assert property (@(posedge mem_clk) disable iff (!mrst_n) // R13
		(mem_status == STAT_IDLE) |-> (mem_strobe_n == STROBE_OFF && !mem_data_oe))
		else $error("strobes active while idle");

	a_stage_status: assert property (@(posedge mem_clk) disable iff (!mrst_n) // R23
		c1_q |-> (mem_status == STAT_ACTIVE && $past(pend_q)))
		else $error("column stage without active status");

	a_read_latch: assert property (@(posedge mem_clk) disable iff (!mrst_n) // R21
		(c1_q && !pg_write_q) |-> ##3 (rd_t_q != $past(rd_t_q)))
		else $error("read data not latched two cycles on");

	a_empty_nolatch: assert property (@(posedge mem_clk) disable iff (!mrst_n) // R7
		(!c1_q && !p2_q) |-> ##2 (rd_t_q == $past(rd_t_q)))
		else $error("data latched from empty pipeline");

	a_rd_exc_gap: assert property (@(posedge mem_clk) disable iff (!mrst_n) // R1
		(st_q == SQ_RL1 && !pg_write_q && pg_exc_q) |=> st_q == SQ_EXI ##1 st_q == SQ_COL)
		else $error("read exception wait wrong");

	a_wr_exc_gap: assert property (@(posedge mem_clk) disable iff (!mrst_n) // R10
		(st_q == SQ_RCL && pg_exc_q && rdy_s2_q)
		|=> st_q == SQ_EXI ##1 st_q == SQ_EXI ##1 st_q == SQ_COL)
		else $error("write exception waits wrong");

	a_exc_return: assert property (@(posedge mem_clk) disable iff (!mrst_n) // R9
		(st_q == SQ_AD2 && pg_exc_q && exc_s2_q != EXC_NONE)
		|=> st_q == SQ_REX ##1 st_q == SQ_AD1)
		else $error("exception did not return to first address");

	a_pdpt_rto: assert property (@(posedge mem_clk) disable iff (!mrst_n) // R16
		(st_q == SQ_COL && st_d != SQ_COL && page_open_q && pg_write_q && pg_pdpt_q)
		|=> st_q == SQ_RTO)
		else $error("peripheral write missing turn-off");

	a_rd_turnoff: assert property (@(posedge mem_clk) disable iff (!mrst_n) // R2
		(st_q == SQ_COL && st_d != SQ_COL && !pg_write_q && pg_to_q == '1)
		|=> st_q == SQ_RTO [*3] ##1 st_q == SQ_AD1)
		else $error("read turn-off cycles wrong");

	a_pdpt_float: assert property (@(posedge mem_clk) disable iff (!mrst_n) // R17
		(c1_q && pg_write_q && pg_pdpt_q) |-> (!mem_data_oe && bus_transceiver_enable))
		else $error("peripheral write drove the bus");

	a_write_drive: assert property (@(posedge mem_clk) disable iff (!mrst_n) // R12
		(c1_q && pg_write_q && !pg_pdpt_q) |-> (mem_data_oe && !mem_we_n && !p2_q))
		else $error("write stage not driven");

endmodule : ssq_sequencer

// File: ssq_sram_model.sv
`timescale 1ns/1ps
module ssq_sram_model
	import ssq_pkg::*;
(
	input wire logic mem_clk,
	input wire logic slow,
	input wire logic [1:0] exc_in,
	input wire logic [ADDR_W-1:0] page_address_bus,
	input wire logic [1:0] mem_status,
	input wire logic [LANE_W-1:0] mem_strobe_n,
	input wire logic mem_we_n,
	input wire logic [DATA_W-1:0] mem_data_out,
	input wire logic mem_data_oe,
	output logic [DATA_W-1:0] mem_data_in,
	output logic mem_ready,
	output logic [1:0] mem_except
);
	logic [DATA_W-1:0] mem_q [16];
	logic [3:0] addr_q;
	logic hit_q;
	logic phase_q;

	initial
	begin
		for (int i = 0; i < 16; i++)
			mem_q[i] = {16{i[3:0]}};
		mem_data_in = '0;
		hit_q = 1'b0;
		phase_q = 1'b0;
	end

	// Slow mode withholds ready every other cycle to force row waits
	assign mem_ready = slow ? phase_q : 1'b1;
	assign mem_except = exc_in;

	always @(posedge mem_clk)
	begin
		phase_q <= ~phase_q;
		hit_q <= (mem_status == STAT_ACTIVE) && mem_we_n;
		addr_q <= page_address_bus[3:0];
		// Bus released between reads: never repeat the last word
		if (hit_q)
			mem_data_in <= mem_q[addr_q];
		else
			mem_data_in <= ~mem_data_in;
		if (mem_status == STAT_ACTIVE && !mem_we_n && mem_data_oe)
			for (int b = 0; b < LANE_W; b++)
				if (!mem_strobe_n[b])
					mem_q[page_address_bus[3:0]][b*8 +: 8] <= mem_data_out[b*8 +: 8];
	end
endmodule : ssq_sram_model

// File: ssq_testbench.sv
`timescale 1ns/1ps
module testbench
	import ssq_pkg::*;
;
	logic sys_clk = 1'b0;
	logic mem_clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic req_pdpt = 1'b0;
	logic req_exc_en = 1'b0;
	logic [TO_W-1:0] req_turnoff = '0;
	logic req_new_page = 1'b0;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [DATA_W-1:0] req_wdata = '0;
	logic [LANE_W-1:0] req_be = '0;
	logic slow = 1'b0;
	logic [1:0] exc_in = 2'h0;
	logic req_ready, rd_valid, mclk_out, we_n, d_oe, te, m_rdy;
	logic [DATA_W-1:0] rd_data, d_out, d_in, rd_seen, w_data;
	logic [ADDR_W-1:0] pab, w_addr;
	logic [1:0] status, m_exc;
	logic [LANE_W-1:0] strobe_n, w_strobe;
	logic w_we, w_oe, w_te;
	logic [DATA_W-1:0] shad [16];
	int err_count = 0;
	int checks = 0;
	int n_c1 = 0;

	initial
		forever #25 sys_clk = ~sys_clk;
	// Link clock phase is unrelated to the system clock
	initial
	begin
		#13;
		forever #80 mem_clk = ~mem_clk;
	end

	ssq_sequencer u_ssq_sequencer (.sys_clk(sys_clk), .rst_n(rst_n), .mem_clk(mem_clk),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
		.req_pdpt(req_pdpt), .req_exc_en(req_exc_en), .req_turnoff(req_turnoff),
		.req_new_page(req_new_page), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_be(req_be), .rd_valid(rd_valid), .rd_data(rd_data),
		.memory_clock_output(mclk_out), .page_address_bus(pab), .mem_status(status),
		.mem_strobe_n(strobe_n), .mem_we_n(we_n), .mem_data_out(d_out),
		.mem_data_oe(d_oe), .mem_data_in(d_in), .bus_transceiver_enable(te),
		.mem_ready(m_rdy), .mem_except(m_exc));

	ssq_sram_model u_ssq_sram_model (.mem_clk(mclk_out), .slow(slow), .exc_in(exc_in),
		.page_address_bus(pab), .mem_status(status), .mem_strobe_n(strobe_n),
		.mem_we_n(we_n), .mem_data_out(d_out), .mem_data_oe(d_oe), .mem_data_in(d_in),
		.mem_ready(m_rdy), .mem_except(m_exc));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	// Pin record of each column start; idle cycles must keep strobes off
	always @(posedge mem_clk)
	begin
		if (status === STAT_ACTIVE)
		begin
			n_c1++;
			w_addr = pab;
			w_strobe = strobe_n;
			w_we = we_n;
			w_data = d_out;
			w_oe = d_oe;
			w_te = te;
		end
		else if (rst_n)
			check(strobe_n, STROBE_OFF);
	end

	task automatic req(input logic wr, input logic pd, input logic ex, input logic [1:0] to,
		input logic np, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [LANE_W-1:0] be);
		int n;
		int c0;
		logic got;
		n = 0;
		got = 1'b0;
		c0 = n_c1;
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_pdpt <= pd;
		req_exc_en <= ex;
		req_turnoff <= to;
		req_new_page <= np;
		req_addr <= a;
		req_wdata <= d;
		req_be <= be;
		do
		begin
			@(negedge sys_clk);
			n++;
		end
		while (req_ready !== 1'b1 && n < 600);
		@(posedge sys_clk);
		req_valid <= 1'b0;
		while (!(req_ready === 1'b1 && n_c1 != c0 && (wr || got)) && n < 600)
		begin
			@(negedge sys_clk);
			n++;
			if (rd_valid === 1'b1)
			begin
				got = 1'b1;
				rd_seen = rd_data;
			end
		end
		if (n >= 600)
		begin
			err_count++;
			conclude();
		end
	endtask : req

	task automatic rd(input logic [3:0] a, input logic np, input logic ex, input logic [1:0] to);
		req(1'b0, 1'b0, ex, to, np, {13'h0, a}, '0, '0);
		check(rd_seen, shad[a]);
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check({status, strobe_n, we_n, d_oe, te, req_ready, rd_valid}, {STAT_IDLE, STROBE_OFF, 5'h16});
		$display("test reset done");
	endtask : t_reset

	task automatic t_write_read();
		req(1'b1, 1'b0, 1'b0, 2'h0, 1'b1, 17'h5, 64'hdeadbeef_cafef00d, 8'h0f);
		check({w_addr, w_strobe, w_we, w_oe, w_te}, {17'h5, 8'hf0, 3'h2});
		check(w_data[31:0], 32'hcafef00d);
		shad[5][31:0] = 32'hcafef00d;
		rd(4'h5, 1'b0, 1'b0, 2'h0);
		rd(4'h6, 1'b0, 1'b0, 2'h0);
		$display("test write_read done");
	endtask : t_write_read

	// Reads issued back to back leave idle bubbles between column starts
	task automatic t_bubbles();
		for (int i = 1; i < 4; i++)
			rd(i[3:0], 1'b0, 1'b0, 2'h0);
		$display("test bubbles done");
	endtask : t_bubbles

	task automatic t_exc();
		exc_in <= 2'h1;
		fork
		begin
			repeat (6) @(posedge mem_clk);
			exc_in <= 2'h0;
		end
		join_none
		rd(4'h7, 1'b1, 1'b1, 2'h0);
		$display("test exception done");
	endtask : t_exc

	task automatic t_slow();
		slow <= 1'b1;
		for (int t = 0; t < 4; t++)
			rd(t[3:0], 1'b1, 1'b0, t[1:0]);
		req(1'b1, 1'b0, 1'b1, 2'h1, 1'b1, 17'h8, 64'h0123456789abcdef, 8'hff);
		shad[8] = 64'h0123456789abcdef;
		rd(4'h8, 1'b1, 1'b1, 2'h0);
		slow <= 1'b0;
		$display("test slow done");
	endtask : t_slow

	task automatic t_pdpt();
		req(1'b1, 1'b1, 1'b0, 2'h2, 1'b1, 17'h9, 64'h1111, 8'hff);
		check({w_oe, w_te, w_we}, 3'h2);
		rd(4'h9, 1'b1, 1'b0, 2'h0);
		$display("test pdpt done");
	endtask : t_pdpt

	initial
	begin
		for (int i = 0; i < 16; i++)
			shad[i] = {16{i[3:0]}};
		// Long enough for the link side to see reset too
		repeat (16) @(posedge sys_clk);
		t_reset();
		rst_n <= 1'b1;
		t_write_read();
		t_bubbles();
		t_exc();
		t_slow();
		t_pdpt();
		conclude();
	end
endmodule : testbench
